// >>> include/asc_cnt_if.sv
// Control and status bundle between the sequencer and one 16-bit counter channel
`timescale 1ns/100ps
interface asc_cnt_if;
  logic wr_mode;
  logic wr_load;
  logic [asc_pkg::CNT_W-1:0] wdata;
  logic do_load;
  logic do_arm;
  logic do_disarm;
  logic do_step;
  logic dec;
  logic reload;
  logic [asc_pkg::CNT_W-1:0] reload_val;
  logic [asc_pkg::CNT_W-1:0] mode;
  logic [asc_pkg::CNT_W-1:0] load;
  logic [asc_pkg::CNT_W-1:0] count;
  logic armed;

  modport ctl (
    output wr_mode, wr_load, wdata, do_load, do_arm, do_disarm, do_step,
    output dec, reload, reload_val,
    input mode, load, count, armed
  );
  modport cnt (
    input wr_mode, wr_load, wdata, do_load, do_arm, do_disarm, do_step,
    input dec, reload, reload_val,
    output mode, load, count, armed
  );
endinterface

// >>> include/asc_pkg.sv
// Shared constants and types for the acquisition sample and scan counting block
package asc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_START = 8'h0C;
  localparam logic [7:0] ADDR_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_SAMPLES = 8'h18;
  localparam logic [7:0] ADDR_SCAN = 8'h1C;
  localparam int ADDR_W = 8;

  // Control register fields and reset value
  localparam int CTRL_CASCADE_BIT = 0;
  localparam logic CTRL_RST = 1'b0;

  // Status register field positions
  localparam int ST_NONEMPTY = 0;
  localparam int ST_HALF_FULL = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_DONE = 4;
  localparam int ST_ACTIVE = 5;
  localparam int ST_COUNTING = 6;
  localparam int ST_HALTED = 7;
  localparam int ST_SCAN_WAIT = 8;
  localparam int ST_W = 9;

  // Counter word width and command word fields
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] CMD_PREFIX = 8'hFF;
  localparam logic [2:0] GRP_SELECT = 3'h0;
  localparam logic [2:0] GRP_ARM = 3'h1;
  localparam logic [2:0] GRP_LOAD = 3'h2;
  localparam logic [2:0] GRP_LOAD_ARM = 3'h3;
  localparam logic [2:0] GRP_DISARM = 3'h6;
  localparam logic [2:0] GRP_STEP = 3'h7;
  localparam logic [1:0] STEP_TAG = 2'h2;
  localparam logic [2:0] CTR_MIN = 3'h1;
  localparam logic [2:0] CTR_MAX = 3'h5;
  localparam int PRETRIG_BIT = 15;

  // Counter channels: scan interval, low sample, high sample
  localparam int N_CH = 3;
  localparam int CH_SCAN = 0;
  localparam int CH_LO = 1;
  localparam int CH_HI = 2;
  localparam logic [8:0] CH_NUMS = {3'h5, 3'h4, 3'h2};

  // Timebase source codes in the mode word
  localparam logic [3:0] TB_5M = 4'h2;
  localparam logic [3:0] TB_1M = 4'hB;
  localparam logic [3:0] TB_100K = 4'hC;
  localparam logic [3:0] TB_10K = 4'hD;
  localparam logic [3:0] TB_1K = 4'hE;
  localparam logic [3:0] TB_100 = 4'hF;
  localparam logic [3:0] TB_SRC5 = 4'h5;

  // Timebase derivation from the bus clock
  localparam int CLK_HZ = 125_000_000;
  localparam int BASE_HZ = 5_000_000;
  localparam int BASE_CYC = CLK_HZ / BASE_HZ;
  localparam int BASE_W = 5;
  localparam int TB_N = 6;
  localparam int DIV_W = 4;
  localparam logic [19:0] TB_DIVS = {4'hA, 4'hA, 4'hA, 4'hA, 4'h5};

  // Pin synchroniser reset levels: trigger, fifth_source_input, half_full_n, nonempty_n
  // All idle high, so no false edge or flag follows reset
  localparam logic [3:0] SYNC_RST = 4'b1111;

  // Acquisition sequencing states
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_PRE = 2'b01,
    ACQ_RUN = 2'b10,
    ACQ_HALT = 2'b11
  } asc_acq_t;

endpackage

// >>> rtl/asc_cnt16.sv
// One 16-bit down counter channel with mode, load and arm state
`timescale 1ns/100ps
module asc_cnt16 (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side
  asc_cnt_if.cnt cb
);

  logic [asc_pkg::CNT_W-1:0] mode_reg, mode_next;
  logic [asc_pkg::CNT_W-1:0] load_reg, load_next;
  logic [asc_pkg::CNT_W-1:0] count_reg, count_next;
  logic armed_reg, armed_next;

  // Command priority: load, step, reload, then counting
  always_comb begin
    mode_next = cb.wr_mode ? cb.wdata : mode_reg;
    load_next = cb.wr_load ? cb.wdata : load_reg;
    armed_next = armed_reg;
    if (cb.do_disarm) begin
      armed_next = 1'b0;
    end
    if (cb.do_arm) begin
      armed_next = 1'b1;
    end
    count_next = count_reg;
    if (cb.do_load) begin
      count_next = load_reg;
    end else if (cb.do_step) begin
      count_next = count_reg - 1'b1;
    end else if (cb.reload) begin
      count_next = cb.reload_val;
    end else if (cb.dec && armed_reg) begin
      count_next = count_reg - 1'b1; // Zero wraps, so load 0 spans 10000 hex
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= '0;
      load_reg <= '0;
      count_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      load_reg <= load_next;
      count_reg <= count_next;
      armed_reg <= armed_next;
    end
  end

  assign cb.mode = mode_reg;
  assign cb.load = load_reg;
  assign cb.count = count_reg;
  assign cb.armed = armed_reg;

endmodule

// >>> rtl/asc_timebase.sv
// Decade timebase ticks derived from the bus clock
`timescale 1ns/100ps
module asc_timebase (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // One-cycle ticks: 5M, 1M, 100k, 10k, 1k, 100 Hz
  output logic [asc_pkg::TB_N-1:0] tick
);

  logic [asc_pkg::BASE_W-1:0] base_reg;
  logic [asc_pkg::BASE_W-1:0] base_next;

  // Base prescaler to the fastest timebase
  always_comb begin
    tick[0] = (base_reg == asc_pkg::BASE_W'(asc_pkg::BASE_CYC - 1));
    base_next = tick[0] ? '0 : base_reg + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_reg <= '0;
    end else begin
      base_reg <= base_next;
    end
  end

  // Chained dividers keep every counter tiny instead of one wide count
  genvar i;
  generate
    for (i = 1; i < asc_pkg::TB_N; i++) begin : g_stage
      logic [asc_pkg::DIV_W-1:0] cnt_reg;
      logic [asc_pkg::DIV_W-1:0] cnt_next;
      logic wrap;
      always_comb begin
        wrap = (cnt_reg == asc_pkg::TB_DIVS[(i-1)*asc_pkg::DIV_W +: asc_pkg::DIV_W] - 1'b1);
        cnt_next = cnt_reg;
        if (tick[i-1]) begin
          cnt_next = wrap ? '0 : cnt_reg + 1'b1;
        end
        tick[i] = tick[i-1] & wrap;
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/asc_top.sv
// Sample counting, scan interval and trigger sequencing with an AHB-Lite slave
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module asc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Conversion side, same clock
  input wire logic conv_pulse,
  input wire logic conv_overrun,
  input wire logic fifo_overflow,
  input wire logic scan_seq_done,
  // Pins from outside the clock domain
  input wire logic external_trigger_n,
  input wire logic fifth_source_input,
  input wire logic conv_fifo_nonempty_n,
  input wire logic conv_fifo_half_full_n,
  // Acquisition controls
  output logic conv_enable,
  output logic sample_count_enable,
  output logic scan_tick,
  output logic scan_wait,
  output logic fifo_clear
);

  asc_cnt_if cif[asc_pkg::N_CH] ();
  logic [asc_pkg::TB_N-1:0] tb_tick;

  // Counter channels and shared timebase
  genvar gi;
  generate
    for (gi = 0; gi < asc_pkg::N_CH; gi++) begin : g_ch
      asc_cnt16 u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cb(cif[gi])
      );
    end
  endgenerate

  asc_timebase u_tb (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tb_tick)
  );

  // True when a counter number is selected by a five-bit command mask
  function automatic logic mask_hit(input logic [4:0] mask, input logic [2:0] num);
    logic [4:0] onehot;
    onehot = 5'h01 << (num - 1'b1);
    return |(mask & onehot);
  endfunction

  // Picks the timebase tick named by a mode word's source field
  function automatic logic tb_pick(input logic [3:0] src, input logic [5:0] t,
                                   input logic s5);
    logic r;
    r = 1'b0;
    case (src)
      asc_pkg::TB_5M: r = t[0];
      asc_pkg::TB_1M: r = t[1];
      asc_pkg::TB_100K: r = t[2];
      asc_pkg::TB_10K: r = t[3];
      asc_pkg::TB_1K: r = t[4];
      asc_pkg::TB_100: r = t[5];
      asc_pkg::TB_SRC5: r = s5;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Bus slave state
  logic wr_pend_reg, wr_pend_next;
  logic [asc_pkg::ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic casc_reg, casc_next;
  logic ahb_take;

  // Data-phase strobes
  logic cmd_wr, data_wr, start_strb, clear_strb, ctrl_wr;
  logic [15:0] cmd;
  logic cmd_ok;
  logic [2:0] grp;

  // Register pointer selected by command words
  logic ptr_load_reg, ptr_load_next;
  logic [2:0] ptr_ctr_reg, ptr_ctr_next;

  // Synchronisers, edges and acquisition state
  logic [3:0] sync1_reg, sync2_reg;
  logic trig_prev_reg, src5_prev_reg;
  logic trig_fall, src5_rise, trigger, error_evt;
  asc_pkg::asc_acq_t acq_reg, acq_next;
  logic ovr_reg, ovr_next, ovf_reg, ovf_next, done_reg, done_next;
  logic conv_en_reg, cnt_en_reg, fclr_reg;
  logic counted, lo_zero, acq_done;
  logic scan_dec, scan_fire;
  logic stick_reg, swait_reg, swait_next;
  logic [asc_pkg::ST_W-1:0] status;

  // Zero-wait slave: every transfer is OKAY and never stretched
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign ahb_take = hsel & htrans[1] & hready;

  // Status word assembly
  assign status = {swait_reg, (acq_reg == asc_pkg::ACQ_HALT), cnt_en_reg,
                   (acq_reg != asc_pkg::ACQ_IDLE), done_reg, ovf_reg, ovr_reg,
                   ~sync2_reg[1], ~sync2_reg[0]};

  // Address phase capture and registered read data
  always_comb begin
    wr_pend_next = ahb_take & hwrite;
    wr_addr_next = ahb_take ? haddr[asc_pkg::ADDR_W-1:0] : wr_addr_reg;
    rdata_next = '0;
    if (ahb_take && !hwrite) begin
      case (haddr[asc_pkg::ADDR_W-1:0])
        asc_pkg::ADDR_CTRL: rdata_next = 32'(casc_reg);
        asc_pkg::ADDR_STATUS: rdata_next = 32'(status);
        asc_pkg::ADDR_SAMPLES: rdata_next = {cif[asc_pkg::CH_HI].count,
                                             cif[asc_pkg::CH_LO].count};
        asc_pkg::ADDR_SCAN: rdata_next = 32'(cif[asc_pkg::CH_SCAN].count);
        default: rdata_next = '0;
      endcase
    end
  end

  // Write strobes, valid in the data phase only
  always_comb begin
    cmd_wr = wr_pend_reg & (wr_addr_reg == asc_pkg::ADDR_CMD);
    data_wr = wr_pend_reg & (wr_addr_reg == asc_pkg::ADDR_DATA);
    ctrl_wr = wr_pend_reg & (wr_addr_reg == asc_pkg::ADDR_CTRL);
    start_strb = wr_pend_reg & (wr_addr_reg == asc_pkg::ADDR_START);
    clear_strb = wr_pend_reg & (wr_addr_reg == asc_pkg::ADDR_CLEAR);
    cmd = hwdata[15:0];
    cmd_ok = cmd_wr & (cmd[15:8] == asc_pkg::CMD_PREFIX);
    grp = cmd[7:5];
    casc_next = ctrl_wr ? hwdata[asc_pkg::CTRL_CASCADE_BIT] : casc_reg;
  end

  // Mode or load register pointer for data writes
  always_comb begin
    ptr_load_next = ptr_load_reg;
    ptr_ctr_next = ptr_ctr_reg;
    if (cmd_ok && grp == asc_pkg::GRP_SELECT && !cmd[4] &&
        cmd[2:0] >= asc_pkg::CTR_MIN && cmd[2:0] <= asc_pkg::CTR_MAX) begin
      ptr_load_next = cmd[3];
      ptr_ctr_next = cmd[2:0];
    end
  end

  // Command and data routing to each counter channel
  generate
    for (gi = 0; gi < asc_pkg::N_CH; gi++) begin : g_route
      localparam logic [2:0] NUM = asc_pkg::CH_NUMS[3*gi +: 3];
      assign cif[gi].wdata = hwdata[15:0];
      assign cif[gi].wr_mode = data_wr & ~ptr_load_reg & (ptr_ctr_reg == NUM);
      assign cif[gi].wr_load = data_wr & ptr_load_reg & (ptr_ctr_reg == NUM);
      assign cif[gi].do_load = cmd_ok & mask_hit(cmd[4:0], NUM) &
                               ((grp == asc_pkg::GRP_LOAD) | (grp == asc_pkg::GRP_LOAD_ARM));
      assign cif[gi].do_arm = cmd_ok & mask_hit(cmd[4:0], NUM) &
                              ((grp == asc_pkg::GRP_ARM) | (grp == asc_pkg::GRP_LOAD_ARM));
      assign cif[gi].do_disarm = cmd_ok & mask_hit(cmd[4:0], NUM) &
                                 (grp == asc_pkg::GRP_DISARM);
      assign cif[gi].do_step = cmd_ok & (grp == asc_pkg::GRP_STEP) &
                               (cmd[4:3] == asc_pkg::STEP_TAG) & (cmd[2:0] == NUM);
    end
  endgenerate

  // Edge detection on synchronised pins, second stage only
  always_comb begin
    trig_fall = trig_prev_reg & ~sync2_reg[3];
    src5_rise = ~src5_prev_reg & sync2_reg[2];
    trigger = start_strb | trig_fall;
    error_evt = conv_overrun | fifo_overflow;
  end

  // Sample counting: low per conversion, high per low wrap
  always_comb begin
    counted = conv_pulse & (acq_reg == asc_pkg::ACQ_RUN);
    lo_zero = counted & cif[asc_pkg::CH_LO].armed &
              (cif[asc_pkg::CH_LO].count == asc_pkg::CNT_ONE);
    acq_done = lo_zero & (~casc_reg |
               (cif[asc_pkg::CH_HI].count == asc_pkg::CNT_ONE));
  end

  // Low and high channel stepping; finish restores the armed start counts
  assign cif[asc_pkg::CH_LO].dec = counted;
  assign cif[asc_pkg::CH_LO].reload = acq_done;
  assign cif[asc_pkg::CH_LO].reload_val = cif[asc_pkg::CH_LO].load - 1'b1;
  assign cif[asc_pkg::CH_HI].dec = casc_reg & lo_zero;
  assign cif[asc_pkg::CH_HI].reload = casc_reg & acq_done;
  assign cif[asc_pkg::CH_HI].reload_val = cif[asc_pkg::CH_HI].load;

  // Scan interval: count timebase periods while converting, fire at one
  always_comb begin
    scan_dec = conv_en_reg & tb_pick(cif[asc_pkg::CH_SCAN].mode[11:8], tb_tick,
                                     src5_rise);
    scan_fire = scan_dec & cif[asc_pkg::CH_SCAN].armed &
                (cif[asc_pkg::CH_SCAN].count == asc_pkg::CNT_ONE);
  end
  assign cif[asc_pkg::CH_SCAN].dec = scan_dec;
  assign cif[asc_pkg::CH_SCAN].reload = scan_fire;
  assign cif[asc_pkg::CH_SCAN].reload_val = cif[asc_pkg::CH_SCAN].load;

  // Sequence end holds off until the next interval pulse; set wins
  always_comb begin
    swait_next = (swait_reg & ~scan_fire) | (scan_seq_done & conv_en_reg);
    if (acq_next == asc_pkg::ACQ_IDLE || acq_next == asc_pkg::ACQ_HALT) begin
      swait_next = 1'b0;
    end
  end

  // Acquisition sequencer
  always_comb begin
    acq_next = acq_reg;
    case (acq_reg)
      asc_pkg::ACQ_IDLE: begin
        if (trigger && cif[asc_pkg::CH_LO].armed) begin
          acq_next = cif[asc_pkg::CH_LO].mode[asc_pkg::PRETRIG_BIT] ?
                     asc_pkg::ACQ_PRE : asc_pkg::ACQ_RUN;
        end
      end
      asc_pkg::ACQ_PRE: begin
        if (trigger) begin
          acq_next = asc_pkg::ACQ_RUN;
        end
      end
      asc_pkg::ACQ_RUN: begin
        if (acq_done) begin
          acq_next = asc_pkg::ACQ_IDLE;
        end
      end
      asc_pkg::ACQ_HALT: acq_next = asc_pkg::ACQ_HALT;
      default: acq_next = asc_pkg::ACQ_IDLE;
    endcase
    if (error_evt && acq_reg != asc_pkg::ACQ_IDLE) begin
      acq_next = asc_pkg::ACQ_HALT;
    end
    if (clear_strb) begin
      acq_next = asc_pkg::ACQ_IDLE;
    end
  end

  // Sticky flags: a new event in the clearing cycle survives the clear
  always_comb begin
    ovr_next = (ovr_reg & ~clear_strb) | conv_overrun;
    ovf_next = (ovf_reg & ~clear_strb) | fifo_overflow;
    done_next = (done_reg & ~clear_strb) | acq_done;
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg <= '0;
      casc_reg <= asc_pkg::CTRL_RST;
      ptr_load_reg <= 1'b0;
      ptr_ctr_reg <= '0;
      sync1_reg <= asc_pkg::SYNC_RST;
      sync2_reg <= asc_pkg::SYNC_RST;
      trig_prev_reg <= asc_pkg::SYNC_RST[3];
      src5_prev_reg <= asc_pkg::SYNC_RST[2];
      acq_reg <= asc_pkg::ACQ_IDLE;
      ovr_reg <= 1'b0;
      ovf_reg <= 1'b0;
      done_reg <= 1'b0;
      conv_en_reg <= 1'b0;
      cnt_en_reg <= 1'b0;
      fclr_reg <= 1'b0;
      stick_reg <= 1'b0;
      swait_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      casc_reg <= casc_next;
      ptr_load_reg <= ptr_load_next;
      ptr_ctr_reg <= ptr_ctr_next;
      sync1_reg <= {external_trigger_n, fifth_source_input,
                    conv_fifo_half_full_n, conv_fifo_nonempty_n};
      sync2_reg <= sync1_reg;
      trig_prev_reg <= sync2_reg[3];
      src5_prev_reg <= sync2_reg[2];
      acq_reg <= acq_next;
      ovr_reg <= ovr_next;
      ovf_reg <= ovf_next;
      done_reg <= done_next;
      conv_en_reg <= (acq_next == asc_pkg::ACQ_PRE) |
                     (acq_next == asc_pkg::ACQ_RUN);
      cnt_en_reg <= (acq_next == asc_pkg::ACQ_RUN);
      fclr_reg <= clear_strb;
      stick_reg <= scan_fire;
      swait_reg <= swait_next;
    end
  end

  // Registered outputs
  assign conv_enable = conv_en_reg;
  assign sample_count_enable = cnt_en_reg;
  assign scan_tick = stick_reg;
  assign scan_wait = swait_reg;
  assign fifo_clear = fclr_reg;

endmodule

// >>> tb/asc_conv_model.sv
// Conversion source and sample FIFO flag model
`timescale 1ns/100ps
module asc_conv_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // From the block
  input wire logic conv_enable,
  input wire logic fifo_clear,
  // To the block
  output logic conv_pulse,
  output logic scan_seq_done,
  output logic nonempty_n,
  output logic half_full_n
);
  logic [1:0] ph;
  logic [8:0] fill;
  // One conversion each fourth cycle while enabled; fill saturates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 2'h0;
      fill <= 9'h000;
      conv_pulse <= 1'b0;
      scan_seq_done <= 1'b0;
    end else begin
      ph <= conv_enable ? ph + 2'h1 : 2'h0;
      conv_pulse <= conv_enable && ph == 2'h3;
      // Two entries a sequence, far shorter than any scan interval used
      scan_seq_done <= conv_pulse && fill[0];
      fill <= fifo_clear ? 9'h000 : fill + {8'h00, conv_pulse && !fill[8]};
    end
  end
  // Low-true flags follow the fill level
  assign nonempty_n = fill == 9'h000;
  assign half_full_n = fill < 9'h100;
endmodule

// >>> tb/asc_top_asserts.sv
// Concurrent checks on the acquisition counting block outputs
`timescale 1ns/100ps
module asc_top_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Conversion side
  input wire logic conv_overrun,
  input wire logic fifo_overflow,
  input wire logic scan_seq_done,
  // Controls
  input wire logic conv_enable,
  input wire logic sample_count_enable,
  input wire logic scan_tick,
  input wire logic scan_wait,
  input wire logic fifo_clear
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Slave answers at once and always OKAY
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
  chk_count_needs_conv: assert property (sample_count_enable |-> conv_enable)
    else $error("counting without conversions");
  // Either error stops conversions within two edges
  chk_error_halts: assert property ((conv_overrun || fifo_overflow) && conv_enable
    |-> ##[1:2] !conv_enable) else $error("error did not halt");
  chk_tick_single: assert property (scan_tick |=> !scan_tick)
    else $error("scan tick too long");
  chk_wait_cause: assert property ($rose(scan_wait) |-> $past(scan_seq_done))
    else $error("scan wait without sequence end");
  // A tick ends the wait unless a sequence ended in the firing cycle
  chk_wait_ends: assert property (scan_tick |-> !scan_wait || $past(scan_seq_done))
    else $error("scan wait outlived tick");
  chk_clear_pulse: assert property (fifo_clear |=> !fifo_clear)
    else $error("fifo clear too long");
  chk_clear_idle: assert property (fifo_clear |=> !conv_enable)
    else $error("clear left conversions on");
  // Main scenarios
  cov_done: cover property ($fell(sample_count_enable));
  cov_wait: cover property ($rose(scan_wait));
  cov_clear: cover property (fifo_clear);
endmodule

bind asc_top asc_top_asserts asc_top_asserts_i (.hclk, .hresetn, .hreadyout, .hresp,
  .conv_overrun, .fifo_overflow, .scan_seq_done, .conv_enable, .sample_count_enable,
  .scan_tick, .scan_wait, .fifo_clear);

// >>> tb/test_acquisition_sample_scan_counting.sv
// Self-checking bench for the acquisition counting block
`timescale 1ns/100ps
module test_acquisition_sample_scan_counting;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ovr = 1'b0;
  logic ofl = 1'b0;
  logic ext_trig_n = 1'b1;
  logic src5 = 1'b0;
  logic [3:0] s5c = 4'h0;
  logic [16:0] lfsr = 17'h1_45F1;
  logic hready, hresp, cpulse, sdone, ne_n, hf_n, cen, scen, stick, swait, fclr;
  logic [31:0] hrdata;
  int cnt = 0;
  int fail_count = 0;
  int n_checks = 0;
  logic [15:0] scan_modes [4] = '{16'h8225, 16'h8B25, 16'h8C25, 16'h8525};
  int scan_pers [4] = '{25, 125, 1250, 24};

  asc_top asc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .conv_pulse(cpulse),
    .conv_overrun(ovr), .fifo_overflow(ofl), .scan_seq_done(sdone),
    .external_trigger_n(ext_trig_n), .fifth_source_input(src5),
    .conv_fifo_nonempty_n(ne_n), .conv_fifo_half_full_n(hf_n), .conv_enable(cen),
    .sample_count_enable(scen), .scan_tick(stick), .scan_wait(swait), .fifo_clear(fclr));
  asc_conv_model asc_conv_model_i (.hclk, .hresetn, .conv_enable(cen), .fifo_clear(fclr),
    .conv_pulse(cpulse), .scan_seq_done(sdone), .nonempty_n(ne_n), .half_full_n(hf_n));

  always #4 hclk = ~hclk;
  // Source pin period 24 cycles, kept under the 6 MHz edge limit
  always @(posedge hclk) begin
    s5c <= (s5c == 4'hB) ? 4'h0 : s5c + 4'h1;
    if (s5c == 4'hB) src5 <= ~src5;
  end
  // Tally of conversions the block counts
  always @(posedge hclk) if (cpulse === 1'b1 && scen === 1'b1) cnt <= cnt + 1;

  function logic [16:0] lfsr_next(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  // Counted conversions: the loaded count after its single step
  function int exp_cnt(input int n);
    return n - 1;
  endfunction
  function int scan_exp(input int i);
    return (i + 2) * scan_pers[i];
  endfunction

  task close_out;
    $display("counts: %0d checks, %0d mismatches", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task note(input string s);
    $display("test %s ended, mismatches %0d", s, fail_count);
  endtask
  // Bounded wait for a level at a rising edge
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge hclk);
      if (s === v) return;
    end
    fail_count++;
    close_out;
  endtask
  // One AHB-Lite single word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_lvl(hready, 1'b1, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_lvl(hready, 1'b1, 20);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  task cmd(input logic [15:0] c);
    wr(asc_pkg::ADDR_CMD, c);
  endtask
  task cd(input logic [15:0] c, input logic [15:0] d);
    cmd(c);
    wr(asc_pkg::ADDR_DATA, d);
  endtask
  task prog_lo(input logic [15:0] mode, input logic [15:0] n);
    cd(16'hFF04, mode);
    cd(16'hFF0C, n);
    cmd(16'hFF48);
    cmd(16'hFFF4);
    cmd(16'hFF28);
  endtask
  task start;
    wr(asc_pkg::ADDR_START, 16'h0001);
  endtask
  // Trigger by strobe or pin, then count until the run ends
  task run(input logic ext, input int exp);
    cnt = 0;
    if (ext) begin
      ext_trig_n <= 1'b0;
      repeat (3) @(posedge hclk);
      ext_trig_n <= 1'b1;
    end else start;
    wait_lvl(scen, 1'b1, 20);
    wait_lvl(scen, 1'b0, 4000);
    @(posedge hclk);
    chk(exp, cnt);
  endtask

  initial begin
    logic [31:0] q;
    int n;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(asc_pkg::ADDR_CTRL, q);
    chk(32'h0000_0000, q);
    rd(asc_pkg::ADDR_STATUS, q);
    chk(32'h0000_0000, q);
    rd(8'h20, q);
    chk(32'h0000_0000, q);
    // Zero load stands for the full count, so one step leaves FFFF
    prog_lo(16'h1025, 16'h0000);
    rd(asc_pkg::ADDR_SAMPLES, q);
    chk(32'h0000_FFFF, q);
    note("reset");
    // Smallest count, then random ones; each retriggered by the pin
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      n = (i == 0) ? 2 : 3 + lfsr % 13;
      prog_lo(16'h1025, n[15:0]);
      run(1'b0, exp_cnt(n));
      run(1'b1, exp_cnt(n));
    end
    rd(asc_pkg::ADDR_STATUS, q);
    chk(32'h0000_0011, q & 32'h0000_0011);
    note("single");
    // Pretrigger: first trigger converts uncounted
    prog_lo(16'h9025, 16'h0005);
    cnt = 0;
    start;
    repeat (40) @(posedge hclk);
    chk(32'h0000_0002, 32'({cen, scen}));
    chk(32'h0000_0000, cnt);
    run(1'b0, exp_cnt(5));
    note("pretrigger");
    // Cascade with high load one ends at the first low wrap
    lfsr = lfsr_next(lfsr);
    n = 4 + lfsr % 9;
    wr(asc_pkg::ADDR_CTRL, 16'h0001);
    cd(16'hFF04, 16'h1025);
    cd(16'hFF0C, n[15:0] - 16'h0001);
    cd(16'hFF48, 16'h0000);
    cmd(16'hFF28);
    cd(16'hFF05, 16'h0025);
    cd(16'hFF0D, 16'h0001);
    cmd(16'hFF70);
    run(1'b0, n - 1);
    rd(asc_pkg::ADDR_SAMPLES, q);
    chk(32'h0001_FFFF, q);
    wr(asc_pkg::ADDR_CTRL, 16'h0000);
    note("cascade");
    // Each error halts a long run until the clear strobe
    for (int i = 0; i < 2; i++) begin
      prog_lo(16'h1025, 16'hFFFF);
      start;
      repeat (10) @(posedge hclk);
      ovr <= (i == 0);
      ofl <= (i == 1);
      @(posedge hclk);
      ovr <= 1'b0;
      ofl <= 1'b0;
      rd(asc_pkg::ADDR_STATUS, q);
      chk(32'h0000_00A0 | (32'h0000_0004 << i), q & 32'h0000_00AC);
      wr(asc_pkg::ADDR_CLEAR, 16'h0001);
      repeat (6) @(posedge hclk);
      rd(asc_pkg::ADDR_STATUS, q);
      chk(32'h0000_0000, q);
    end
    note("errors");
    // Scan interval per timebase, timed between later ticks
    for (int i = 0; i < 4; i++) begin
      cd(16'hFF02, scan_modes[i]);
      cd(16'hFF0A, 16'h0002);
      cmd(16'hFF42);
      cd(16'hFFF2, 16'h0002 + i[15:0]);
      cmd(16'hFF22);
      prog_lo(16'h1025, 16'hFFFF);
      start;
      wait_lvl(stick, 1'b1, 6000);
      wait_lvl(stick, 1'b1, 6000);
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (stick !== 1'b1 && n < 6000);
      chk(scan_exp(i), n);
      // Only the long 100 kHz run fills the model FIFO past half
      rd(asc_pkg::ADDR_STATUS, q);
      chk({31'h0, i == 2}, (q >> asc_pkg::ST_HALF_FULL) & 32'h0000_0001);
      wr(asc_pkg::ADDR_CLEAR, 16'h0001);
    end
    note("scan");
    close_out;
  end
endmodule
